// file: tsc_pkg.sv
`default_nettype none
package tsc_pkg;
  localparam int unsigned tsc_num_ch = 3;
  localparam logic [7:0] tsc_ch_stride = 8'h40;
  localparam logic [7:0] tsc_ofs_flags = 8'h20;
  localparam logic [7:0] tsc_ofs_ien = 8'h24;
  localparam logic [7:0] tsc_ofs_idis = 8'h28;
  localparam logic [7:0] tsc_ofs_mask = 8'h2C;
  localparam logic [7:0] tsc_ofs_cmd = 8'hC0;
  localparam logic [7:0] tsc_ofs_route = 8'hC4;
  localparam int unsigned tsc_bit_ovf = 0;
  localparam int unsigned tsc_bit_lovr = 1;
  localparam int unsigned tsc_bit_cpa = 2;
  localparam int unsigned tsc_bit_cpb = 3;
  localparam int unsigned tsc_bit_cpc = 4;
  localparam int unsigned tsc_bit_lda = 5;
  localparam int unsigned tsc_bit_ldb = 6;
  localparam int unsigned tsc_bit_etrg = 7;
  localparam int unsigned tsc_bit_clkrun = 16;
  localparam int unsigned tsc_bit_mira = 17;
  localparam int unsigned tsc_bit_mirb = 18;
  localparam int unsigned tsc_bit_sync = 0;
  localparam int unsigned tsc_pos_xc0 = 0;
  localparam int unsigned tsc_pos_xc1 = 2;
  localparam int unsigned tsc_pos_xc2 = 4;
  localparam logic [7:0] tsc_rst_flags = 8'h00;
  localparam logic [7:0] tsc_rst_mask = 8'h00;
  localparam logic [5:0] tsc_rst_route = 6'h00;
  localparam logic [1:0] tsc_htrans_nonseq = 2'h2;
  localparam logic [2:0] tsc_hsize_word = 3'h2;

  // per-channel event strobes and live state from the counter datapath
  typedef struct packed {
    logic wave_mode;
    logic clk_running;
    logic line_a_pin;
    logic line_a_drive;
    logic line_b_pin;
    logic line_b_drive;
    logic ext_trigger;
    logic capture_a_load;
    logic capture_b_load;
    logic capcomp_a_read;
    logic capcomp_b_read;
    logic match_a;
    logic match_b;
    logic match_c;
    logic overflow;
  } tsc_ch_evt_t;

  typedef struct packed {
    logic [tsc_num_ch-1:0] sw_trigger;
    logic [tsc_num_ch-1:0] irq;
    logic ext_clock_input_0;
    logic ext_clock_input_1;
    logic ext_clock_input_2;
  } tsc_blk_out_t;

  typedef enum logic [1:0] {
    tsc_src_pin = 2'b00,
    tsc_src_none = 2'b01,
    tsc_src_first = 2'b10,
    tsc_src_second = 2'b11
  } tsc_src_t;
endpackage
`default_nettype wire

// file: tsc_status_ctrl.sv
// Contract
// - a status read clears all sticky flags of that channel and its requests
// - status bit 18 mirrors line B: pin in capture, driven level in waveform
// - status bit 17 mirrors line A: pin in capture, driven level in waveform
// - status bit 16 shows live counter clock enabled state
// - bit 7 sets on external trigger, holds until status read
// - bit 6 sets on capture B load in capture mode
// - bit 5 sets on capture A load in capture mode
// - bit 4 sets on compare C match in either mode
// - bit 3 sets on compare B match in waveform mode
// - bit 2 sets on compare A match in waveform mode
// - bit 1 sets on second capture load before read, capture mode
// - bit 0 sets on counter overflow
// - enable strobe ones set mask bits, zeros no effect
// - disable strobe ones clear mask bits, zeros no effect
// - mask reads enabled sources, resets to zero
// - block command bit 0 triggers all channels at once
// - input 2 source: pin 2, none, ch0 line A, ch1 line A
// - input 1 source: pin 1, none, ch0 line A, ch2 line A
// - input 0 source: pin 0, none, ch1 line A, ch2 line A
// - mode bit one is waveform, zero is capture, gates flags and mirrors
//
// Our own choice: the AHB-Lite interface to the registers.
`default_nettype none
module tsc_status_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire tsc_pkg::tsc_ch_evt_t [tsc_pkg::tsc_num_ch-1:0] ch_evt,
  input wire logic clock_input_pin_0,
  input wire logic clock_input_pin_1,
  input wire logic clock_input_pin_2,
  output tsc_pkg::tsc_blk_out_t blk_out
);
  import tsc_pkg::*;

  // ---------------------------------------------------------------
  // address phase capture
  // ---------------------------------------------------------------
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  logic [7:0] flags_ff [tsc_num_ch];
  logic [7:0] mask_ff [tsc_num_ch];
  logic [tsc_num_ch-1:0] pend_a_ff;
  logic [tsc_num_ch-1:0] pend_b_ff;
  logic [5:0] route_ff;
  tsc_blk_out_t out_ff;

  logic addr_ok;
  logic rd_take;
  logic wr_take;
  logic [7:0] a_ofs;
  assign addr_ok = hsel && hready && (htrans == tsc_htrans_nonseq) && (haddr[31:8] == 24'h000000);
  assign rd_take = addr_ok && !hwrite;
  assign wr_take = addr_ok && hwrite;
  assign a_ofs = haddr[7:0];

  // channel index of an offset, or tsc_num_ch if none
  function automatic logic [1:0] ch_of(input logic [7:0] ofs);
    logic [1:0] r;
    r = 2'h3;
    if (ofs < tsc_ofs_cmd) begin
      r = ofs[7:6];
    end
    return r;
  endfunction

  // 2-bit source select, shared by the three routing fields
  function automatic logic pick_src(input logic [1:0] sel, input logic pin, input logic first, input logic second);
    logic r;
    r = 1'b0;
    case (tsc_src_t'(sel))
      tsc_src_pin: r = pin;
      tsc_src_none: r = 1'b0;
      tsc_src_first: r = first;
      tsc_src_second: r = second;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= wr_take;
      wr_addr_ff <= a_ofs;
    end
  end

  // ---------------------------------------------------------------
  // write decode, data phase
  // ---------------------------------------------------------------
  logic [1:0] w_ch;
  logic [7:0] w_reg;
  logic cmd_wr;
  logic route_wr;
  assign w_ch = ch_of(wr_addr_ff);
  assign w_reg = {2'b00, wr_addr_ff[5:0]};
  assign cmd_wr = wr_pend_ff && (wr_addr_ff == tsc_ofs_cmd);
  assign route_wr = wr_pend_ff && (wr_addr_ff == tsc_ofs_route);

  // ---------------------------------------------------------------
  // per-channel flags and mask
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < tsc_num_ch; i++) begin
        flags_ff[i] <= tsc_rst_flags;
        mask_ff[i] <= tsc_rst_mask;
      end
      pend_a_ff <= '0;
      pend_b_ff <= '0;
    end else begin
      for (int i = 0; i < tsc_num_ch; i++) begin
        logic [7:0] set_v;
        logic wave;
        logic rd_me;
        set_v = 8'h00;
        wave = ch_evt[i].wave_mode;
        rd_me = rd_take && (ch_of(a_ofs) == i[1:0]) && ({2'b00, a_ofs[5:0]} == tsc_ofs_flags);
        set_v[tsc_bit_etrg] = ch_evt[i].ext_trigger;
        set_v[tsc_bit_ldb] = !wave && ch_evt[i].capture_b_load;
        set_v[tsc_bit_lda] = !wave && ch_evt[i].capture_a_load;
        set_v[tsc_bit_cpc] = ch_evt[i].match_c;
        set_v[tsc_bit_cpb] = wave && ch_evt[i].match_b;
        set_v[tsc_bit_cpa] = wave && ch_evt[i].match_a;
        set_v[tsc_bit_lovr] = !wave && ((ch_evt[i].capture_a_load && pend_a_ff[i] && !ch_evt[i].capcomp_a_read) ||
                                        (ch_evt[i].capture_b_load && pend_b_ff[i] && !ch_evt[i].capcomp_b_read));
        set_v[tsc_bit_ovf] = ch_evt[i].overflow;
        flags_ff[i] <= (rd_me ? 8'h00 : flags_ff[i]) | set_v;
        if (ch_evt[i].capture_a_load && !wave) begin
          pend_a_ff[i] <= 1'b1;
        end else if (ch_evt[i].capcomp_a_read) begin
          pend_a_ff[i] <= 1'b0;
        end
        if (ch_evt[i].capture_b_load && !wave) begin
          pend_b_ff[i] <= 1'b1;
        end else if (ch_evt[i].capcomp_b_read) begin
          pend_b_ff[i] <= 1'b0;
        end
        if (wr_pend_ff && (w_ch == i[1:0])) begin
          if (w_reg == tsc_ofs_ien) begin
            mask_ff[i] <= mask_ff[i] | hwdata[7:0];
          end
          if (w_reg == tsc_ofs_idis) begin
            mask_ff[i] <= mask_ff[i] & ~hwdata[7:0];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // block routing register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route_ff <= tsc_rst_route;
    end else if (route_wr) begin
      route_ff <= hwdata[5:0];
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] nxt_rdata;
  always_comb begin
    logic [1:0] c;
    c = ch_of(a_ofs);
    nxt_rdata = 32'h00000000;
    if (c != 2'h3) begin
      case ({2'b00, a_ofs[5:0]})
        tsc_ofs_flags: begin
          nxt_rdata[7:0] = flags_ff[c];
          nxt_rdata[tsc_bit_clkrun] = ch_evt[c].clk_running;
          nxt_rdata[tsc_bit_mira] = ch_evt[c].wave_mode ? ch_evt[c].line_a_drive : ch_evt[c].line_a_pin;
          nxt_rdata[tsc_bit_mirb] = ch_evt[c].wave_mode ? ch_evt[c].line_b_drive : ch_evt[c].line_b_pin;
        end
        tsc_ofs_mask: nxt_rdata[7:0] = mask_ff[c];
        default: nxt_rdata = 32'h00000000;
      endcase
    end else if (a_ofs == tsc_ofs_route) begin
      nxt_rdata[5:0] = route_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_take) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // block outputs
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ff <= '0;
    end else begin
      out_ff.sw_trigger <= {tsc_num_ch{cmd_wr && hwdata[tsc_bit_sync]}};
      for (int i = 0; i < tsc_num_ch; i++) begin
        out_ff.irq[i] <= |(flags_ff[i] & mask_ff[i]);
      end
      out_ff.ext_clock_input_0 <= pick_src(route_ff[tsc_pos_xc0 +: 2], clock_input_pin_0,
                                           ch_evt[1].line_a_drive, ch_evt[2].line_a_drive);
      out_ff.ext_clock_input_1 <= pick_src(route_ff[tsc_pos_xc1 +: 2], clock_input_pin_1,
                                           ch_evt[0].line_a_drive, ch_evt[2].line_a_drive);
      out_ff.ext_clock_input_2 <= pick_src(route_ff[tsc_pos_xc2 +: 2], clock_input_pin_2,
                                           ch_evt[0].line_a_drive, ch_evt[1].line_a_drive);
    end
  end

  assign blk_out = out_ff;
  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule // tsc_status_ctrl
`default_nettype wire

// file: tsc_status_ctrl_props.sv
`default_nettype none
module tsc_status_ctrl_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire tsc_pkg::tsc_ch_evt_t [tsc_pkg::tsc_num_ch-1:0] ch_evt,
  input wire logic clock_input_pin_0,
  input wire logic clock_input_pin_1,
  input wire logic clock_input_pin_2,
  input wire tsc_pkg::tsc_blk_out_t blk_out
);
  import tsc_pkg::*;
  logic wr_ff, rd_ff, up_ff;
  logic [7:0] a_ff;
  logic [5:0] rt_ff;
  logic [2:0] mir_ff;
  logic [2:0] xsel;
  wire logic take = hsel && hready && htrans == tsc_htrans_nonseq && haddr[31:8] == 24'h0;
  wire logic cmd1 = wr_ff && a_ff == tsc_ofs_cmd && hwdata[0];
  function automatic logic pick(input logic [1:0] s, input logic p, input logic a, input logic b);
    return (s == 2'h0) ? p : (s == 2'h1) ? 1'b0 : (s == 2'h2) ? a : b;
  endfunction
  always_comb begin
    xsel[2] = pick(rt_ff[5:4], clock_input_pin_2, ch_evt[0].line_a_drive, ch_evt[1].line_a_drive);
    xsel[1] = pick(rt_ff[3:2], clock_input_pin_1, ch_evt[0].line_a_drive, ch_evt[2].line_a_drive);
    xsel[0] = pick(rt_ff[1:0], clock_input_pin_0, ch_evt[1].line_a_drive, ch_evt[2].line_a_drive);
  end
  // ----------------------------------------
  // bus tracking
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      up_ff <= 1'b0;
      a_ff <= 8'h00;
      rt_ff <= 6'h00;
      mir_ff <= 3'h0;
    end else begin
      wr_ff <= take && hwrite;
      rd_ff <= take && !hwrite;
      up_ff <= 1'b1;
      a_ff <= haddr[7:0];
      if (wr_ff && a_ff == tsc_ofs_route) begin
        rt_ff <= hwdata[5:0];
      end
      mir_ff <= ch_evt[1].wave_mode ? {ch_evt[1].line_b_drive, ch_evt[1].line_a_drive, ch_evt[1].clk_running}
                                    : {ch_evt[1].line_b_pin, ch_evt[1].line_a_pin, ch_evt[1].clk_running};
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_SYNC_FIRE: assert property (cmd1 |=> blk_out.sw_trigger == 3'h7) else $error("no trigger");
  AST_SYNC_IDLE: assert property (!cmd1 |=> blk_out.sw_trigger == 3'h0) else $error("stray trigger");
  AST_ROUTE_OUT: assert property (up_ff |-> {blk_out.ext_clock_input_2, blk_out.ext_clock_input_1,
    blk_out.ext_clock_input_0} == $past(xsel)) else $error("clock route wrong");
  AST_ROUTE_READ: assert property (rd_ff && a_ff == tsc_ofs_route |-> hrdata == {26'h0, rt_ff})
    else $error("route readback wrong");
  AST_MIR_B: assert property (rd_ff && a_ff == 8'h60 |-> hrdata[18] == mir_ff[2]) else $error("line b mirror");
  AST_MIR_A: assert property (rd_ff && a_ff == 8'h60 |-> hrdata[17] == mir_ff[1]) else $error("line a mirror");
  AST_CLK_RUN: assert property (rd_ff && a_ff == 8'h60 |-> hrdata[16] == mir_ff[0]) else $error("clock state");
  AST_IRQ_CLEAR: assert property (take && !hwrite && haddr[7:0] == 8'h60 && ch_evt[1][8:0] == 9'h0
    |-> ##2 !blk_out.irq[1]) else $error("irq kept after status read");
  cover property (blk_out.sw_trigger == 3'h7);
  cover property ($rose(blk_out.irq[1]));
  cover property (rd_ff && a_ff == tsc_ofs_route);
endmodule // tsc_status_ctrl_props
`default_nettype wire

// file: tsc_far_model.sv
`default_nettype none
module tsc_far_model (
  input wire logic hclk,
  output tsc_pkg::tsc_ch_evt_t [tsc_pkg::tsc_num_ch-1:0] ch_evt,
  output logic [2:0] pin
);
  import tsc_pkg::*;
  tsc_ch_evt_t [2:0] lvl = '0;
  tsc_ch_evt_t [2:0] pls = '0;
  initial pin = 3'h0;
  assign ch_evt = lvl | pls;
  // one-cycle event strobe
  task automatic pulse(input int c, input tsc_ch_evt_t p);
    pls[c] <= p;
    @(posedge hclk);
    pls[c] <= '0;
    @(posedge hclk);
  endtask
endmodule // tsc_far_model
`default_nettype wire

// file: test_tsc_status_ctrl.sv
`default_nettype none
module test_tsc_status_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import tsc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = tsc_hsize_word;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp;
  logic [2:0] pin;
  tsc_ch_evt_t [2:0] ch_evt;
  tsc_blk_out_t blk_out;
  int errors = 0;
  int checks_done = 0;
  always #2 hclk = ~hclk;
  tsc_far_model u_far (.hclk(hclk), .ch_evt(ch_evt), .pin(pin));
  tsc_status_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ch_evt(ch_evt), .clock_input_pin_0(pin[0]),
    .clock_input_pin_1(pin[1]), .clock_input_pin_2(pin[2]), .blk_out(blk_out));
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ----------------------------------------
  // bus master
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= tsc_htrans_nonseq;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd("status", 8'h60, 32'h0);
    rd("mask", 8'hAC, 32'h0);
    rd("route", tsc_ofs_route, 32'h0);
    rd("enable strobe", 8'h24, 32'h0);
    rd("unmapped", 8'h30, 32'h0);
  endtask
  task automatic t_mask();
    xfer(1'b1, 8'hA4, 32'h0000_00A5);
    xfer(1'b1, 8'hA4, 32'hFFFF_FF00);
    rd("mask set", 8'hAC, 32'h0000_00A5);
    xfer(1'b1, 8'hA8, 32'h0000_0005);
    rd("mask clear", 8'hAC, 32'h0000_00A0);
  endtask
  task automatic t_flags();
    u_far.lvl[1] <= '{clk_running: 1'b1, line_a_pin: 1'b1, line_b_drive: 1'b1, default: 1'b0};
    xfer(1'b1, 8'h64, 32'h0000_0001);
    chk("irq idle", blk_out.irq, 3'h0);
    u_far.pulse(1, '{ext_trigger: 1'b1, capture_a_load: 1'b1, capture_b_load: 1'b1, match_a: 1'b1,
      match_c: 1'b1, overflow: 1'b1, default: 1'b0});
    u_far.pulse(1, '{capture_a_load: 1'b1, default: 1'b0});
    chk("irq set", blk_out.irq, 3'h2);
    rd("capture flags", 8'h60, 32'h0003_00F3);
    @(posedge hclk);
    chk("irq after read", blk_out.irq, 3'h0);
    rd("cleared", 8'h60, 32'h0003_0000);
    u_far.lvl[1] <= '{wave_mode: 1'b1, line_a_pin: 1'b1, line_b_drive: 1'b1, default: 1'b0};
    u_far.pulse(1, '{match_a: 1'b1, match_b: 1'b1, capture_a_load: 1'b1, capture_b_load: 1'b1, default: 1'b0});
    rd("wave flags", 8'h60, 32'h0004_000C);
  endtask
  task automatic t_sync();
    xfer(1'b1, tsc_ofs_cmd, 32'h0000_0001);
    @(posedge hclk);
    chk("trigger", blk_out.sw_trigger, 3'h7);
    @(posedge hclk);
    chk("trigger end", blk_out.sw_trigger, 3'h0);
    xfer(1'b1, tsc_ofs_cmd, 32'h0000_0000);
    @(posedge hclk);
    chk("no trigger", blk_out.sw_trigger, 3'h0);
  endtask
  task automatic t_route();
    logic [3:0] x2, x1, x0;
    logic [1:0] k2, k1, k0;
    x2 = 4'b0101;
    x1 = 4'b1100;
    x0 = 4'b1001;
    u_far.lvl[0] <= '{line_a_drive: 1'b1, default: 1'b0};
    u_far.lvl[2] <= '{line_a_drive: 1'b1, default: 1'b0};
    u_far.pin <= 3'b101;
    for (int s = 0; s < 4; s++) begin
      k2 = 2'(s);
      k1 = 2'(s + 1);
      k0 = 2'(s + 2);
      xfer(1'b1, tsc_ofs_route, {26'h0, k2, k1, k0});
      rd("route", tsc_ofs_route, {26'h0, k2, k1, k0});
      chk("ext clocks", {blk_out.ext_clock_input_2, blk_out.ext_clock_input_1, blk_out.ext_clock_input_0},
        {x2[k2], x1[k1], x0[k0]});
    end
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_mask();
    t_flags();
    t_sync();
    t_route();
    give_verdict();
  end
endmodule // test_tsc_status_ctrl
bind tsc_status_ctrl tsc_status_ctrl_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .ch_evt(ch_evt),
  .clock_input_pin_0(clock_input_pin_0), .clock_input_pin_1(clock_input_pin_1),
  .clock_input_pin_2(clock_input_pin_2), .blk_out(blk_out));
`default_nettype wire
